// File: src/mcuidt_decode.v
// instruction decode and instruction-cycle timing for the 8-bit core
`timescale 1ns/10ps
`default_nettype none
`include "mcuidt_map.vh"

// Notes on behaviour
// (RULE_01) base set plus eight extended instructions
// (RULE_02) one word, four instructions two words
// (RULE_03) split word into opcode and operands
// (RULE_04) classify byte, bit, literal, control
// (RULE_05) d clear to accumulator, set to file
// (RULE_06) bit field picks affected bit
// (RULE_07) literal constant, optional pointer, or none
// (RULE_08) control: address, fast mode, table mode
// (RULE_09) lone second word executes as no-op
// (RULE_10) one cycle; taken or skip adds no-op
// (RULE_11) two-word instructions take two cycles
// (RULE_12) instruction cycle is four oscillator periods
// (RULE_13) taken two-word branch takes three cycles
// (RULE_14) access bit: access bank or bank selector
// (RULE_15) fast select uses shadow copies when set
// (RULE_16) table mode none, post inc/dec, pre-inc
// (RULE_17) flush fetched word after change or skip
module mcuidt_decode (
  // clock and reset
  input  wire        clk_sys,
  input  wire        srst,
  // fetch side
  input  wire [15:0] fetch_word,
  input  wire        fetch_valid,
  // execution feedback
  input  wire        cond_true,
  // instruction cycle timing
  output wire        cycle_strobe,
  output reg  [1:0]  osc_phase_reg,
  output wire        fetch_take,
  // decoded fields
  output reg         instr_valid_reg,
  output reg  [15:0] opcode_word_reg,
  output reg  [15:0] second_word_reg,
  output reg  [1:0]  group_reg,
  output reg         extended_reg,
  output reg         two_word_reg,
  output reg         is_nop_reg,
  output reg  [7:0]  file_addr_reg,
  output reg         dest_to_file_reg,
  output reg         use_bank_selector_reg,
  output reg  [2:0]  bit_num_reg,
  output reg  [7:0]  literal_reg,
  output reg  [1:0]  indirect_pointer_sel_reg,
  output reg         literal_to_pointer_reg,
  output reg         fast_shadow_reg,
  output reg  [1:0]  table_mode_reg,
  output reg         table_access_reg,
  output reg         pc_change_reg,
  output reg         cond_instr_reg,
  // status
  output reg         flush_reg,
  output reg  [1:0]  state_reg
);

  localparam ST_EXEC  = `MCUIDT_ST_EXEC;
  localparam ST_FLUSH = `MCUIDT_ST_FLUSH;
  localparam ST_WORD2 = `MCUIDT_ST_WORD2;

  reg  [1:0] state_next;
  reg  [1:0] grp;
  reg        ext;
  reg        dbl;
  reg        pcchg;
  reg        cnd;
  reg        tbl;
  reg        fast;
  reg        lfsr;
  wire [15:0] w = fetch_word;
  wire        word2_tag = (w[15:12] == `MCUIDT_WORD2_TAG);

  // quarter-rate enable: one instruction cycle per four clocks
  always @(posedge clk_sys) begin
    if (srst)
      osc_phase_reg <= 2'h0;
    else
      osc_phase_reg <= osc_phase_reg + 2'h1; // [RULE_12]
  end
  assign cycle_strobe = (osc_phase_reg == `MCUIDT_OSC_PER_CYC); // [RULE_12]
  assign fetch_take   = cycle_strobe & fetch_valid;

  // combinational classification of the fetched word
  always @* begin
    grp   = `MCUIDT_GRP_BYTE;
    ext   = 1'b0;
    dbl   = 1'b0;
    pcchg = 1'b0;
    cnd   = 1'b0;
    tbl   = 1'b0;
    fast  = 1'b0;
    lfsr  = 1'b0;
    case (w[15:12]) // [RULE_03] [RULE_04]
      4'h0: begin
        if (w[11:8] == 4'h0) begin
          grp = `MCUIDT_GRP_CTRL;
          if (w[7:2] == 6'h02) tbl = 1'b1; // table read/write
          if (w[7:1] == 7'h08) begin
            pcchg = 1'b1; // return-from-interrupt / return
            fast  = w[0];
          end
        end else if (w[11:8] == 4'h1) begin
          grp = `MCUIDT_GRP_LIT; // bank selector move, literal ops
        end else begin
          grp = (w[11:8] >= 4'h8) ? `MCUIDT_GRP_LIT : `MCUIDT_GRP_BYTE;
        end
      end
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
        grp = `MCUIDT_GRP_BYTE;
        if (w[15:11] == 5'b01100 || w[15:10] == 6'b001011 || w[15:10] == 6'b010011 ||
            w[15:12] == 4'h3 && w[11:10] != 2'b01 && w[11:10] != 2'b10)
          cnd = (w[15:12] != 4'h1) && (w[15:12] != 4'h2) && (w[15:12] != 4'h5);
      end
      4'h7, 4'h8, 4'h9, 4'ha, 4'hb: begin
        grp = `MCUIDT_GRP_BIT;
        cnd = (w[15:12] == 4'ha) || (w[15:12] == 4'hb); // bit test skips
      end
      4'hc: begin
        grp = `MCUIDT_GRP_BYTE;
        dbl = 1'b1; // [RULE_02] file-to-file move
      end
      4'hd: begin
        grp   = `MCUIDT_GRP_CTRL;
        pcchg = 1'b1; // relative branch and call
      end
      4'he: begin
        grp = `MCUIDT_GRP_CTRL;
        if (w[11:8] == 4'he || w[11:8] == 4'hf) begin
          grp   = w[11:9] == 3'h7 && w[8] ? `MCUIDT_GRP_CTRL : `MCUIDT_GRP_LIT;
          dbl   = (w[11:7] == 5'h1c) || (w[11:8] == 4'hf); // [RULE_02]
          lfsr  = (w[11:6] == 6'h38);
          pcchg = (w[11:8] == 4'hf);
          ext   = (w[11:8] == 4'h8) || (w[11:6] != 6'h38) && !w[8]; // [RULE_01]
        end else if (w[11:9] == 3'h6) begin
          dbl   = 1'b1; // absolute call, fast select in bit 8
          pcchg = 1'b1;
          fast  = w[8];
        end else if (w[11:8] == 4'h8) begin
          grp = `MCUIDT_GRP_LIT;
          ext = 1'b1; // [RULE_01] extended pointer arithmetic group
        end else begin
          cnd = 1'b1; // conditional branches
        end
      end
      default: begin
        grp = `MCUIDT_GRP_CTRL; // [RULE_09] lone second word behaves as no-op
      end
    endcase
  end

  // sequencing: flush slot after taken flow change, second-word slot
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_EXEC: begin
        if (fetch_take && dbl)
          state_next = ST_WORD2; // [RULE_11]
        else if (fetch_take && (pcchg || (cnd && cond_true)))
          state_next = ST_FLUSH; // [RULE_10] [RULE_17]
      end
      ST_WORD2: begin
        if (fetch_take)
          state_next = (pc_change_reg || (cond_instr_reg && cond_true)) ?
                       ST_FLUSH : ST_EXEC; // [RULE_13]
      end
      ST_FLUSH: begin
        if (fetch_take)
          state_next = ST_EXEC;
      end
      default: state_next = ST_EXEC;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      state_reg                <= ST_EXEC;
      instr_valid_reg          <= 1'b0;
      opcode_word_reg          <= 16'h0000;
      second_word_reg          <= 16'h0000;
      group_reg                <= `MCUIDT_GRP_BYTE;
      extended_reg             <= 1'b0;
      two_word_reg             <= 1'b0;
      is_nop_reg               <= 1'b0;
      file_addr_reg            <= 8'h00;
      dest_to_file_reg         <= 1'b0;
      use_bank_selector_reg    <= 1'b0;
      bit_num_reg              <= 3'h0;
      literal_reg              <= 8'h00;
      indirect_pointer_sel_reg <= 2'h0;
      literal_to_pointer_reg   <= 1'b0;
      fast_shadow_reg          <= 1'b0;
      table_mode_reg           <= `MCUIDT_TBL_NONE;
      table_access_reg         <= 1'b0;
      pc_change_reg            <= 1'b0;
      cond_instr_reg           <= 1'b0;
      flush_reg                <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (fetch_take) begin
        flush_reg       <= 1'b0;
        instr_valid_reg <= 1'b0;
        if (state_reg == ST_FLUSH) begin
          is_nop_reg <= 1'b1; // [RULE_17] discarded prefetch runs as no-op
          flush_reg  <= 1'b1;
        end else if (state_reg == ST_WORD2) begin
          second_word_reg <= w;
          instr_valid_reg <= 1'b1;
          is_nop_reg      <= 1'b0;
        end else begin
          opcode_word_reg          <= w; // [RULE_03]
          group_reg                <= grp; // [RULE_04]
          extended_reg             <= ext;
          two_word_reg             <= dbl;
          is_nop_reg               <= word2_tag; // [RULE_09]
          instr_valid_reg          <= !dbl;
          file_addr_reg            <= w[`MCUIDT_F_MSB:`MCUIDT_F_LSB];
          dest_to_file_reg         <= w[`MCUIDT_D_POS]; // [RULE_05]
          use_bank_selector_reg    <= w[`MCUIDT_A_POS]; // [RULE_14]
          bit_num_reg              <= w[`MCUIDT_BIT_MSB:`MCUIDT_BIT_LSB]; // [RULE_06]
          literal_reg              <= w[7:0]; // [RULE_07]
          indirect_pointer_sel_reg <= w[`MCUIDT_FSR_MSB:`MCUIDT_FSR_LSB]; // [RULE_07]
          literal_to_pointer_reg   <= lfsr;
          fast_shadow_reg          <= fast; // [RULE_15]
          table_mode_reg           <= w[`MCUIDT_MM_MSB:`MCUIDT_MM_LSB]; // [RULE_16]
          table_access_reg         <= tbl; // [RULE_08]
          pc_change_reg            <= pcchg;
          cond_instr_reg           <= cnd;
        end
      end else if (cycle_strobe) begin
        instr_valid_reg <= 1'b0;
      end
    end
  end

endmodule // mcuidt_decode
`default_nettype wire

// File: src/mcuidt_map.vh
// constants for the instruction decode and timing block
`ifndef MCUIDT_MAP_VH
`define MCUIDT_MAP_VH
// instruction groups
`define MCUIDT_GRP_BYTE    2'h0
`define MCUIDT_GRP_BIT     2'h1
`define MCUIDT_GRP_LIT     2'h2
`define MCUIDT_GRP_CTRL    2'h3
// oscillator phase that ends each four-period instruction cycle
`define MCUIDT_OSC_PER_CYC 2'h3
// operand field positions
`define MCUIDT_F_LSB       0
`define MCUIDT_F_MSB       7
`define MCUIDT_A_POS       8
`define MCUIDT_D_POS       9
`define MCUIDT_BIT_LSB     9
`define MCUIDT_BIT_MSB     11
`define MCUIDT_S_POS       0
`define MCUIDT_MM_LSB      0
`define MCUIDT_MM_MSB      1
`define MCUIDT_FSR_LSB     4
`define MCUIDT_FSR_MSB     5
// table pointer modes
`define MCUIDT_TBL_NONE    2'h0
`define MCUIDT_TBL_POSTINC 2'h1
`define MCUIDT_TBL_POSTDEC 2'h2
`define MCUIDT_TBL_PREINC  2'h3
// second word marker in top nibble
`define MCUIDT_WORD2_TAG   4'hf
// execution unit states
`define MCUIDT_ST_EXEC     2'h0
`define MCUIDT_ST_FLUSH    2'h1
`define MCUIDT_ST_WORD2    2'h2
`endif

// File: testbench/mcuidt_properties.sv
// assertion checker for the decode and timing block
`timescale 1ns/10ps
`default_nettype none
`include "mcuidt_map.vh"
module mcuidt_chk (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // fetch side
  input wire logic [15:0] fetch_word,
  input wire logic        fetch_valid,
  input wire logic        cycle_strobe,
  input wire logic [1:0]  osc_phase_reg,
  input wire logic        fetch_take,
  // decoded fields
  input wire logic        instr_valid_reg,
  input wire logic [15:0] second_word_reg,
  input wire logic [1:0]  group_reg,
  input wire logic        is_nop_reg,
  input wire logic        dest_to_file_reg,
  input wire logic        use_bank_selector_reg,
  input wire logic [2:0]  bit_num_reg,
  input wire logic        flush_reg,
  input wire logic [1:0]  state_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_period; cycle_strobe |=> !cycle_strobe [*3] ##1 cycle_strobe; endproperty
  a_period: assert property (p_period) else $error("strobe spacing wrong");
  property p_take; fetch_take |-> cycle_strobe && fetch_valid && osc_phase_reg == 2'h3; endproperty
  a_take: assert property (p_take) else $error("take off phase");
  property p_dest;
    fetch_take && state_reg == `MCUIDT_ST_EXEC ##1 group_reg == `MCUIDT_GRP_BYTE && !is_nop_reg
      |-> dest_to_file_reg == $past(fetch_word[9]);
  endproperty
  a_dest: assert property (p_dest) else $error("destination bit wrong");
  property p_bank;
    fetch_take && state_reg == `MCUIDT_ST_EXEC ##1 group_reg == `MCUIDT_GRP_BYTE && !is_nop_reg
      |-> use_bank_selector_reg == $past(fetch_word[8]);
  endproperty
  a_bank: assert property (p_bank) else $error("access bit wrong");
  property p_bit;
    fetch_take && state_reg == `MCUIDT_ST_EXEC ##1 group_reg == `MCUIDT_GRP_BIT && !is_nop_reg
      |-> bit_num_reg == $past(fetch_word[11:9]);
  endproperty
  a_bit: assert property (p_bit) else $error("bit number wrong");
  property p_lone;
    fetch_take && state_reg == `MCUIDT_ST_EXEC && fetch_word[15:12] == `MCUIDT_WORD2_TAG
      |=> is_nop_reg;
  endproperty
  a_lone: assert property (p_lone) else $error("lone second word not a no-op");
  property p_word2;
    fetch_take && state_reg == `MCUIDT_ST_WORD2 |=> instr_valid_reg && second_word_reg == $past(fetch_word);
  endproperty
  a_word2: assert property (p_word2) else $error("second word not completed");
  property p_flush; fetch_take && state_reg == `MCUIDT_ST_FLUSH |=> is_nop_reg && flush_reg; endproperty
  a_flush: assert property (p_flush) else $error("fetched word not discarded");
endmodule // mcuidt_chk
`default_nettype wire

// File: testbench/mcuidt_prog_mem.sv
// program memory model feeding words to the fetch side
`timescale 1ns/10ps
`default_nettype none
module mcuidt_prog_mem (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // fetch handshake
  input  wire logic        fetch_take,
  input  wire logic        stall,
  output logic      [15:0] fetch_word,
  output logic             fetch_valid
);
  logic [15:0] mem [0:31];
  logic [4:0]  ptr_reg;
  // two-word instructions sit in consecutive locations
  always @(posedge clk_sys) begin
    if (srst)
      ptr_reg <= 5'h00;
    else if (fetch_take)
      ptr_reg <= ptr_reg + 5'h01;
  end
  // a stalled bus shows the inverse so a stale word never decodes right
  assign fetch_valid = !stall;
  assign fetch_word = stall ? ~mem[ptr_reg] : mem[ptr_reg];
endmodule // mcuidt_prog_mem
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the decode and timing block
`timescale 1ns/10ps
`default_nettype none
`include "mcuidt_map.vh"
module testbench;
  logic clk_sys, srst, cond_true, stall;
  wire [15:0] fetch_word, second_word_reg, opcode_word_reg;
  wire [7:0] file_addr_reg, literal_reg;
  wire [2:0] bit_num_reg;
  wire [1:0] osc_phase_reg, group_reg, table_mode_reg, state_reg, indirect_pointer_sel_reg;
  wire extended_reg, literal_to_pointer_reg, table_access_reg, pc_change_reg, cond_instr_reg;
  wire fetch_valid, cycle_strobe, fetch_take, instr_valid_reg, two_word_reg, is_nop_reg;
  wire dest_to_file_reg, use_bank_selector_reg, fast_shadow_reg, flush_reg;
  int fail_count = 0;
  int tests_run = 0;
  mcuidt_prog_mem pm (.clk_sys, .srst, .fetch_take, .stall, .fetch_word, .fetch_valid);
  mcuidt_decode uut (.clk_sys, .srst, .fetch_word, .fetch_valid, .cond_true, .cycle_strobe,
    .osc_phase_reg, .fetch_take, .instr_valid_reg, .opcode_word_reg, .second_word_reg,
    .group_reg, .extended_reg, .two_word_reg, .is_nop_reg, .file_addr_reg, .dest_to_file_reg,
    .use_bank_selector_reg, .bit_num_reg, .literal_reg, .indirect_pointer_sel_reg,
    .literal_to_pointer_reg, .fast_shadow_reg, .table_mode_reg, .table_access_reg,
    .pc_change_reg, .cond_instr_reg, .flush_reg, .state_reg);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic conclude;
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // wait for the next take, then one edge for the fields to land
  task automatic take;
    int n;
    n = 0;
    while (fetch_take !== 1'b1 && n < 16) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 16) begin
      fail_count++;
      conclude();
    end
    @(negedge clk_sys);
  endtask
  initial begin
    srst = 1'b1;
    cond_true = 1'b0;
    stall = 1'b1;
    pm.mem = '{16'h2655, 16'h25aa, 16'h8b12, 16'h0e3c, 16'h0008, 16'h0009, 16'h000a, 16'h000b,
      16'hf123, 16'hef10, 16'hf000, 16'h2655, 16'h0011, 16'h2655, 16'ha4e1, 16'h2655,
      16'hee1c, 16'hf0ab, 16'he812, 16'ha4e1, 16'h2655, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    repeat (12) @(negedge clk_sys);
    srst = 1'b0;
    repeat (6) @(negedge clk_sys);
    stall = 1'b0;
    take();
    chk(group_reg, `MCUIDT_GRP_BYTE);
    chk(dest_to_file_reg, 16'h1);
    chk(use_bank_selector_reg, 16'h0);
    chk(file_addr_reg, 16'h55);
    chk(opcode_word_reg, 16'h2655);
    take();
    chk(dest_to_file_reg, 16'h0);
    chk(use_bank_selector_reg, 16'h1);
    take();
    chk(group_reg, `MCUIDT_GRP_BIT);
    chk(bit_num_reg, 16'h5);
    take();
    chk(group_reg, `MCUIDT_GRP_LIT);
    chk(literal_reg, 16'h3c);
    for (int i = 0; i < 4; i++) begin
      take();
      chk(group_reg, `MCUIDT_GRP_CTRL);
      chk(table_mode_reg, i[15:0]);
      chk(table_access_reg, 16'h1);
    end
    take();
    chk(is_nop_reg, 16'h1);
    take();
    chk(two_word_reg, 16'h1);
    take();
    chk(instr_valid_reg, 16'h1);
    chk(second_word_reg, 16'hf000);
    take();
    chk(flush_reg, 16'h1);
    chk(is_nop_reg, 16'h1);
    take();
    chk(fast_shadow_reg, 16'h1);
    chk(pc_change_reg, 16'h1);
    take();
    chk(flush_reg, 16'h1);
    // skip taken: condition held high across the take of the test word
    cond_true = 1'b1;
    take();
    cond_true = 1'b0;
    chk(cond_instr_reg, 16'h1);
    take();
    chk(flush_reg, 16'h1);
    chk(is_nop_reg, 16'h1);
    take();
    chk(literal_to_pointer_reg, 16'h1);
    chk(indirect_pointer_sel_reg, 16'h1);
    chk(instr_valid_reg, 16'h0);
    take();
    chk(instr_valid_reg, 16'h1);
    chk(flush_reg, 16'h0);
    take();
    chk(extended_reg, 16'h1);
    chk(group_reg, `MCUIDT_GRP_LIT);
    // skip not taken: no discarded slot follows
    take();
    chk(cond_instr_reg, 16'h1);
    take();
    chk(flush_reg, 16'h0);
    chk(is_nop_reg, 16'h0);
    conclude();
  end
endmodule // testbench
bind mcuidt_decode mcuidt_chk chk_i (.clk_sys, .srst, .fetch_word, .fetch_valid, .cycle_strobe,
  .osc_phase_reg, .fetch_take, .instr_valid_reg, .second_word_reg, .group_reg, .is_nop_reg,
  .dest_to_file_reg, .use_bank_selector_reg, .bit_num_reg, .flush_reg, .state_reg);
`default_nettype wire
